// ### sfr_cfg.svh
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH
// Register addresses
`define ADDR_INDIRECT 6'h00
`define ADDR_TIMER0 6'h01
`define ADDR_PC_LOW 6'h02
`define ADDR_STATUS 6'h03
`define ADDR_FSEL 6'h04
`define ADDR_PORT_B 6'h06
`define ADDR_POWER 6'h08
`define ADDR_WAKEUP 6'h09
`define ADDR_PC_HIGH_BUFFER 6'h0A
`define SFR_TOP 6'h0F
// Status bit positions
`define ST_C 0
`define ST_HALF 1
`define ST_Z 2
`define ST_PD 3
`define ST_TO 4
// Power control bit positions
`define PW_WDT 7
`define PW_EIRQ 6
`define PW_LVD 5
`define PW_LVR 3
`define PW_CMP 2
// Reset values
`define RST_STATUS 8'h18
`define RST_POWER 8'h88
`define RST_WAKEUP 6'h3F
`define RST_ZERO8 8'h00
`define RST_PC 10'h000
`define PC_ONE 10'h001
`define RST_HIBUF 3'h0
`endif

// ### sfr_pkg.sv
package sfr_pkg;
  // Program counter load kinds issued by the core
  typedef enum logic [2:0] {
    pc_step, pc_short_jump, pc_short_call, pc_long_jump, pc_long_call, pc_return, pc_hold
  } pc_op_type;
  // Timer0 clock source choices
  typedef enum logic [1:0] {
    src_instruction, src_pin, src_low_osc
  } timer_src_type;
endpackage

// ### mcu_core_special_registers.sv
// Function
// RQ1 - Indirect port redirects via file-select pointer
// RQ2 - Timer0 read returns live count
// RQ3 - Timer0 write replaces count immediately
// RQ4 - Timer0 clock from instruction, pin, oscillator
// RQ5 - PC low byte resets zero, increments
// RQ6 - PC high bits only via buffer
// RQ7 - Short jump: PC9 from buffer bit1
// RQ8 - Short call: buffer high bits, push return
// RQ9 - Long jump loads all ten bits
// RQ10 - Long call loads ten bits, pushes
// RQ11 - Carry set on carry or no-borrow
// RQ12 - Half carry from low nibble
// RQ13 - Zero flag from logical result
// RQ14 - Power-down flag set clrwdt, cleared sleep
// RQ15 - Expiry flag set clrwdt/sleep, cleared timeout
// RQ16 - Pointer low six bits select register
// RQ17 - Port read: pin or latch by option
// RQ18 - Port write stores output latch
// RQ19 - Interrupt select routes pin zero
// RQ20 - Power control enables, reset values
// RQ21 - Six wake-up enables, reset ones
// RQ22 - General purpose bits plain storage
// RQ23 - Return pops stack into PC
// RQ24 - Banks 1-3 map onto bank 0
// RQ25 - Self-pointing indirect reads zero, ignores write
`include "sfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mcu_core_special_registers #(
  parameter int PC_WIDTH = 10,
  parameter int STACK_DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [7:0] gpr_addr,
  output logic gpr_rd,
  output logic gpr_wr,
  output logic [7:0] gpr_wdata,
  input wire logic [7:0] gpr_rdata,
  input wire sfr_pkg::pc_op_type pc_op,
  input wire logic [PC_WIDTH-1:0] instr_target,
  output logic [PC_WIDTH-1:0] pc,
  input wire logic alu_flag_we,
  input wire logic carry_in_flag,
  input wire logic half_in_flag,
  input wire logic zero_we,
  input wire logic zero_in_flag,
  input wire logic sleep_exec,
  input wire logic clrwdt_exec,
  input wire logic watchdog_timeout,
  input wire logic [1:0] timer0_mode_settings,
  input wire logic timer0_edge_falling,
  input wire logic low_osc_config,
  input wire logic external_timer_clock_pin,
  input wire logic low_osc_clk,
  input wire logic instruction_clock,
  input wire logic port_readback_select,
  input wire logic [5:0] port_dir_out,
  input wire logic [5:0] port_b_pin,
  output logic [5:0] port_b_out,
  output logic ext_irq_routing,
  output logic ext_irq_pin,
  output logic watchdog_enable,
  output logic low_voltage_detect_enable,
  output logic low_voltage_reset_enable,
  output logic comparator_enable,
  output logic [5:0] pin_wakeup_bits
);
  // ************************************************************
  // Storage
  // ************************************************************
  logic [PC_WIDTH-1:0] next_pc; // Program counter next value
  logic [PC_WIDTH-1:0] stack_mem [STACK_DEPTH]; // Return stack
  logic [$clog2(STACK_DEPTH)-1:0] stack_ptr; // Next free stack slot; top entry is one below
  logic [7:0] status_flags; // Arithmetic and reset-cause flags
  logic [7:0] file_select_pointer; // Indirect pointer
  logic [7:0] port_b_data; // Output latch plus spare bits
  logic [7:0] power_control; // Power enables
  logic [5:0] pin_wakeup_enable; // Wake-up enables
  logic [2:0] pc_high_buffer; // Spare bit and two PC high bits
  logic [7:0] timer0_count; // Live timer0 count
  logic [1:0] pin_sync_a; // Pin clock synchroniser stage one
  logic [1:0] pin_sync_b; // Stage two
  logic [2:0] pin_last; // Edge history for timer clocks
  logic [5:0] port_sync_a; // Port pins stage one
  logic [5:0] port_sync_b; // Port pins stage two

  // ************************************************************
  // Address decode
  // ************************************************************
  // Banks fold onto bank 0 for the special and the general range alike [RQ24]
  wire logic [5:0] direct_loc = reg_addr[5:0];
  wire logic is_indirect = direct_loc == `ADDR_INDIRECT;
  // Indirect access follows the pointer; bank bits ignored [RQ1] [RQ16]
  wire logic [5:0] eff_loc = is_indirect ? file_select_pointer[5:0] : direct_loc;
  // Pointer aimed at itself gives no target [RQ25]
  wire logic self_point = is_indirect && (file_select_pointer[5:0] == `ADDR_INDIRECT);
  wire logic is_sfr = eff_loc <= `SFR_TOP;
  wire logic wr_ok = reg_wr && !self_point;
  wire logic wr_timer = wr_ok && eff_loc == `ADDR_TIMER0;
  wire logic wr_pcl = wr_ok && eff_loc == `ADDR_PC_LOW;
  wire logic wr_status = wr_ok && eff_loc == `ADDR_STATUS;
  wire logic wr_fsel = wr_ok && eff_loc == `ADDR_FSEL;
  wire logic wr_port = wr_ok && eff_loc == `ADDR_PORT_B;
  wire logic wr_power = wr_ok && eff_loc == `ADDR_POWER;
  wire logic wr_wake = wr_ok && eff_loc == `ADDR_WAKEUP;
  wire logic wr_hibuf = wr_ok && eff_loc == `ADDR_PC_HIGH_BUFFER;

  // ************************************************************
  // Timer0 clock selection
  // ************************************************************
  // Pick source from mode settings and configuration word [RQ4]
  wire sfr_pkg::timer_src_type timer_src = !timer0_mode_settings[0] ? sfr_pkg::src_instruction :
    ((timer0_mode_settings[1] || low_osc_config) ? sfr_pkg::src_low_osc : sfr_pkg::src_pin);
  wire logic pin_now = pin_sync_b[0];
  wire logic osc_now = pin_sync_b[1];
  wire logic pin_rise = pin_now && !pin_last[0];
  wire logic pin_fall = !pin_now && pin_last[0];
  wire logic osc_rise = osc_now && !pin_last[1];
  wire logic osc_fall = !osc_now && pin_last[1];
  // Edge polarity option applies to pin and oscillator alike
  wire logic pin_tick = timer0_edge_falling ? pin_fall : pin_rise;
  wire logic osc_tick = timer0_edge_falling ? osc_fall : osc_rise;
  wire logic inst_tick = instruction_clock && !pin_last[2];
  wire logic timer_tick = (timer_src == sfr_pkg::src_instruction) ? inst_tick :
    (timer_src == sfr_pkg::src_pin) ? pin_tick : osc_tick;

  // ************************************************************
  // Read path
  // ************************************************************
  // Port read: input pins show level, output pins by option [RQ17]
  wire logic [5:0] port_read = (port_dir_out & (port_readback_select ? port_b_data[5:0] : port_sync_b))
    | (~port_dir_out & port_sync_b);
  logic [7:0] sfr_read; // Selected special register value
  always_comb
  begin
    case (eff_loc)
      `ADDR_TIMER0: sfr_read = timer0_count; // Live count [RQ2]
      `ADDR_PC_LOW: sfr_read = pc[7:0];
      `ADDR_STATUS: sfr_read = status_flags;
      `ADDR_FSEL: sfr_read = file_select_pointer;
      `ADDR_PORT_B: sfr_read = {port_b_data[7:6], port_read};
      `ADDR_POWER: sfr_read = power_control;
      `ADDR_WAKEUP: sfr_read = {2'h0, pin_wakeup_enable};
      // High PC bits are not visible; only the buffer reads back [RQ6]
      `ADDR_PC_HIGH_BUFFER: sfr_read = {5'h00, pc_high_buffer};
      default: sfr_read = `RST_ZERO8; // Unused slots and self pointing read zero [RQ25]
    endcase
  end
  wire logic [7:0] next_rdata = (!reg_rd || self_point) ? `RST_ZERO8 : (is_sfr ? sfr_read : gpr_rdata);

  // ************************************************************
  // Program counter
  // ************************************************************
  wire logic [PC_WIDTH-1:0] pc_plus = pc + `PC_ONE;
  // A low byte write is a direct load, so it lands even while the core holds [RQ5] [RQ6]
  wire logic [PC_WIDTH-1:0] pc_written = {pc[PC_WIDTH-1:8], reg_wdata};
  always_comb
  begin
    case (pc_op)
      // Short jump: nine bits from word, top bit from buffer [RQ7]
      sfr_pkg::pc_short_jump: next_pc = {pc_high_buffer[1], instr_target[8:0]};
      // Short call: two bits from buffer [RQ8]
      sfr_pkg::pc_short_call: next_pc = {pc_high_buffer[1:0], instr_target[7:0]};
      sfr_pkg::pc_long_jump: next_pc = instr_target; // [RQ9]
      sfr_pkg::pc_long_call: next_pc = instr_target; // [RQ10]
      sfr_pkg::pc_return: next_pc = stack_mem[stack_ptr - 1'b1]; // [RQ23]
      sfr_pkg::pc_hold: next_pc = wr_pcl ? pc_written : pc;
      // Writing the low byte keeps the high bits untouched [RQ6]
      default: next_pc = wr_pcl ? pc_written : pc_plus; // [RQ5]
    endcase
  end

  // PC register resets to zero [RQ5]
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pc <= `RST_PC;
    else
      pc <= next_pc;
  end

  // Calls push the following address, returns pop [RQ8] [RQ10] [RQ23]
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      stack_ptr <= '0;
    else if (pc_op == sfr_pkg::pc_short_call || pc_op == sfr_pkg::pc_long_call)
      stack_ptr <= stack_ptr + 1'b1;
    else if (pc_op == sfr_pkg::pc_return)
      stack_ptr <= stack_ptr - 1'b1;
  end

  // Stack array has no reset; contents matter only after a push
  always_ff @(posedge clk)
  begin
    if (pc_op == sfr_pkg::pc_short_call || pc_op == sfr_pkg::pc_long_call)
      stack_mem[stack_ptr] <= pc_plus;
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  // Hardware events are applied after software writes, so they win
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      status_flags <= `RST_STATUS;
    else
    begin
      if (wr_status)
        status_flags <= reg_wdata; // Spare bits plain storage [RQ22]
      if (alu_flag_we)
      begin
        status_flags[`ST_C] <= carry_in_flag; // [RQ11]
        status_flags[`ST_HALF] <= half_in_flag; // [RQ12]
      end
      if (zero_we)
        status_flags[`ST_Z] <= zero_in_flag; // [RQ13]
      if (clrwdt_exec)
      begin
        status_flags[`ST_PD] <= 1'b1; // [RQ14]
        status_flags[`ST_TO] <= 1'b1; // [RQ15]
      end
      if (sleep_exec)
      begin
        status_flags[`ST_PD] <= 1'b0; // [RQ14]
        status_flags[`ST_TO] <= 1'b1; // [RQ15]
      end
      if (watchdog_timeout)
        status_flags[`ST_TO] <= 1'b0; // [RQ15]
    end
  end

  // ************************************************************
  // Plain control registers
  // ************************************************************
  // Pointer, port latch, power, wake-up and high buffer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      file_select_pointer <= `RST_ZERO8;
      port_b_data <= `RST_ZERO8;
      power_control <= `RST_POWER; // [RQ20]
      pin_wakeup_enable <= `RST_WAKEUP; // [RQ21]
      pc_high_buffer <= `RST_HIBUF;
    end
    else
    begin
      if (wr_fsel)
        file_select_pointer <= reg_wdata; // [RQ16]
      if (wr_port)
        port_b_data <= reg_wdata; // Latch regardless of direction [RQ18]
      if (wr_power)
        power_control <= reg_wdata; // [RQ20] [RQ22]
      if (wr_wake)
        pin_wakeup_enable <= reg_wdata[5:0]; // [RQ21]
      if (wr_hibuf)
        pc_high_buffer <= reg_wdata[2:0]; // [RQ6] [RQ22]
    end
  end

  // ************************************************************
  // Timer0
  // ************************************************************
  // A software write overrides any tick in the same cycle [RQ3]
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      timer0_count <= `RST_ZERO8;
    else if (wr_timer)
      timer0_count <= reg_wdata;
    else if (timer_tick)
      timer0_count <= timer0_count + 8'h01;
  end

  // Asynchronous pins pass two stages before any edge logic
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_sync_a <= 2'h0;
      pin_sync_b <= 2'h0;
      pin_last <= 3'h0;
      port_sync_a <= 6'h00;
      port_sync_b <= 6'h00;
    end
    else
    begin
      pin_sync_a <= {low_osc_clk, external_timer_clock_pin};
      pin_sync_b <= pin_sync_a;
      pin_last <= {instruction_clock, pin_sync_b};
      port_sync_a <= port_b_pin;
      port_sync_b <= port_sync_a;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  // Every output is a flop; strobes to data memory lag one cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= `RST_ZERO8;
      gpr_addr <= `RST_ZERO8;
      gpr_rd <= 1'b0;
      gpr_wr <= 1'b0;
      gpr_wdata <= `RST_ZERO8;
      port_b_out <= 6'h00;
      ext_irq_routing <= 1'b0;
      ext_irq_pin <= 1'b0;
      watchdog_enable <= 1'b1;
      low_voltage_detect_enable <= 1'b0;
      low_voltage_reset_enable <= 1'b1;
      comparator_enable <= 1'b0;
      pin_wakeup_bits <= `RST_WAKEUP;
    end
    else
    begin
      reg_rdata <= next_rdata;
      gpr_addr <= {2'h0, eff_loc};
      gpr_rd <= reg_rd && !is_sfr && !self_point;
      gpr_wr <= wr_ok && !is_sfr;
      gpr_wdata <= reg_wdata;
      port_b_out <= port_b_data[5:0];
      ext_irq_routing <= power_control[`PW_EIRQ]; // [RQ19]
      ext_irq_pin <= power_control[`PW_EIRQ] && port_sync_b[0]; // [RQ19]
      watchdog_enable <= power_control[`PW_WDT]; // [RQ20]
      low_voltage_detect_enable <= power_control[`PW_LVD];
      low_voltage_reset_enable <= power_control[`PW_LVR];
      comparator_enable <= power_control[`PW_CMP];
      pin_wakeup_bits <= pin_wakeup_enable; // [RQ21]
    end
  end
endmodule // mcu_core_special_registers
`default_nettype wire

// ### mcu_core_special_registers_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_watch #(
  parameter int PC_WIDTH = 10
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] gpr_addr,
  input wire logic gpr_rd,
  input wire sfr_pkg::pc_op_type pc_op,
  input wire logic [PC_WIDTH-1:0] instr_target,
  input wire logic [PC_WIDTH-1:0] pc,
  input wire logic [5:0] port_b_out,
  input wire logic watchdog_enable,
  input wire logic ext_irq_routing,
  input wire logic [5:0] pin_wakeup_bits
);
  // ****************
  // Core-side checks
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic [5:0] loc; // Bank bits never select anything
  assign loc = reg_addr[5:0];
  a_pc_step: assert property (pc_op == sfr_pkg::pc_step && !reg_wr
    |=> pc == PC_WIDTH'($past(pc) + 1)) else $error("bad pc step");
  a_long_jump: assert property (pc_op == sfr_pkg::pc_long_jump
    |=> pc == $past(instr_target)) else $error("bad long jump");
  a_short_jump: assert property (pc_op == sfr_pkg::pc_short_jump
    |=> pc[8:0] == $past(instr_target[8:0])) else $error("bad short jump");
  a_call_return: assert property (pc_op == sfr_pkg::pc_long_call ##1 pc_op == sfr_pkg::pc_hold
    ##1 pc_op == sfr_pkg::pc_return |=> pc == PC_WIDTH'($past(pc, 3) + 1)) else $error("bad return");
  a_port_latch: assert property (reg_wr && loc == 6'h06
    |-> ##2 port_b_out == $past(reg_wdata[5:0], 2)) else $error("bad port latch");
  a_power_bits: assert property (reg_wr && loc == 6'h08
    |-> ##2 {watchdog_enable, ext_irq_routing} == $past(reg_wdata[7:6], 2)) else $error("bad power bits");
  a_wake_bits: assert property (reg_wr && loc == 6'h09
    |-> ##2 pin_wakeup_bits == $past(reg_wdata[5:0], 2)) else $error("bad wake bits");
  a_gpr_direct: assert property (reg_rd && loc >= 6'h10
    |=> gpr_rd && gpr_addr[5:0] == $past(loc)) else $error("memory read lost");
  c_call_return: cover property (pc_op == sfr_pkg::pc_long_call ##2 pc_op == sfr_pkg::pc_return);
  c_indirect: cover property (reg_rd && loc == 6'h00);
  c_alias: cover property (reg_wr && reg_addr[7:6] != 2'b00);
endmodule // sfr_watch
bind mcu_core_special_registers sfr_watch #(.PC_WIDTH(PC_WIDTH)) watch_i (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .gpr_addr(gpr_addr), .gpr_rd(gpr_rd), .pc_op(pc_op), .instr_target(instr_target), .pc(pc),
  .port_b_out(port_b_out), .watchdog_enable(watchdog_enable), .ext_irq_routing(ext_irq_routing),
  .pin_wakeup_bits(pin_wakeup_bits));
`default_nettype wire

// ### core_data_memory.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************
// Core-side data memory
// ***********************
module core_data_memory (
  input wire logic clk,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] gpr_addr,
  input wire logic gpr_wr,
  input wire logic [7:0] gpr_wdata,
  output logic [7:0] gpr_rdata
);
  logic [7:0] mem [0:63]; // One bank only
  logic [5:0] ptr = 6'h00; // Core's copy of the pointer
  logic [7:0] junk = 8'h5A; // Churns so a stray read is never stable
  wire logic [5:0] loc;
  // Data is needed in the access cycle, before the block's strobes appear
  assign loc = (reg_addr[5:0] == 6'h00) ? ptr : reg_addr[5:0];
  assign gpr_rdata = (loc >= 6'h10) ? mem[loc] : junk;
  always @(posedge clk)
  begin
    junk <= junk + 8'h35;
    if (reg_wr && reg_addr[5:0] == 6'h04)
      ptr <= reg_wdata[5:0];
    if (gpr_wr)
      mem[gpr_addr[5:0]] <= gpr_wdata;
  end
endmodule // core_data_memory
`default_nettype wire

// ### mcu_core_special_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_core_special_registers_test;
  // *******************
  // Stimulus and probes
  // *******************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] ev = 8'h00; // Flag writes, then sleep, clear and timeout pulses
  logic [2:0] tsrc = 3'h0; // Oscillator, timer pin, instruction clock
  logic [1:0] tmode = 2'h0;
  logic tfall = 1'b0; // Pin and oscillator sources count falling edges when set
  logic lcfg = 1'b0; // Configuration word picks the oscillator
  logic rdopt = 1'b0; // Output pins read back the latch when set
  logic [5:0] pdir = 6'h00; // Pin directions, one means output
  logic [5:0] pins = 6'h2A; // Levels on the port pins
  wire logic irq_pin;
  logic [9:0] target = 10'h000;
  sfr_pkg::pc_op_type pc_op = sfr_pkg::pc_hold; // Counter frozen unless moved
  wire logic [7:0] reg_rdata, gpr_addr, gpr_wdata, gpr_rdata;
  wire logic gpr_wr;
  wire logic [9:0] pc;
  wire logic [5:0] port_b_out, wake;
  wire logic [4:0] en; // Watchdog, irq route, detector, voltage reset, comparator
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  mcu_core_special_registers dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .gpr_addr(gpr_addr), .gpr_rd(), .gpr_wr(gpr_wr), .gpr_wdata(gpr_wdata),
    .gpr_rdata(gpr_rdata), .pc_op(pc_op), .instr_target(target), .pc(pc), .alu_flag_we(ev[7]),
    .carry_in_flag(ev[6]), .half_in_flag(ev[5]), .zero_we(ev[4]), .zero_in_flag(ev[3]), .sleep_exec(ev[2]),
    .clrwdt_exec(ev[1]), .watchdog_timeout(ev[0]), .timer0_mode_settings(tmode), .timer0_edge_falling(tfall),
    .low_osc_config(lcfg), .external_timer_clock_pin(tsrc[1]), .low_osc_clk(tsrc[2]),
    .instruction_clock(tsrc[0]), .port_readback_select(rdopt), .port_dir_out(pdir), .port_b_pin(pins),
    .port_b_out(port_b_out), .ext_irq_routing(en[3]), .ext_irq_pin(irq_pin), .watchdog_enable(en[4]),
    .low_voltage_detect_enable(en[2]), .low_voltage_reset_enable(en[1]), .comparator_enable(en[0]),
    .pin_wakeup_bits(wake));
  core_data_memory mem (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .gpr_addr(gpr_addr), .gpr_wr(gpr_wr), .gpr_wdata(gpr_wdata), .gpr_rdata(gpr_rdata));
  initial
  begin
    forever #50 clk = ~clk;
  end
  // Cut a hang short; the whole run needs a few hundred cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      miscompares++;
      final_report();
    end
  end
  // *************
  // Bus and checks
  // *************
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Control outputs sit one flop behind their register, so one more edge passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #1 reg_wr = 1'b0;
    @(posedge clk) #1;
  endtask
  // Read data is registered, so it is judged one edge after the request
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk) #1 reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask
  task automatic op(input sfr_pkg::pc_op_type o, input logic [9:0] t, input logic [9:0] e);
    @(posedge clk) #1 pc_op = o;
    target = t;
    @(posedge clk) #1 pc_op = sfr_pkg::pc_hold;
    chk(pc, e);
  endtask
  task automatic pulse(input logic [7:0] v, input logic [7:0] e);
    @(posedge clk) #1 ev = v;
    @(posedge clk) #1 ev = 8'h00;
    rd(8'h03, e);
  endtask
  // Slow edges so the two-flop synchronisers never miss one
  task automatic ticks(input logic [2:0] m, input int n);
    repeat (2 * n)
    begin
      repeat (3) @(posedge clk);
      #1 tsrc = tsrc ^ m;
    end
    repeat (6) @(posedge clk);
  endtask
  // *********
  // Scenarios
  // *********
  task automatic t_regs();
    chk(pc, 10'h000);
    chk(en, 5'h12);
    chk(wake, 6'h3F);
    rd(8'h03, 8'h18);
    wr(8'h48, 8'h74);
    chk(en, 5'h0D);
    chk(irq_pin, 1'b0);
    rd(8'h08, 8'h74);
    wr(8'h06, 8'hC5);
    chk(port_b_out, 6'h05);
    rd(8'h06, 8'hEA);
    pdir = 6'h0F;
    rdopt = 1'b1;
    rd(8'h06, 8'hE5);
    rdopt = 1'b0;
    rd(8'h06, 8'hEA);
    pins = 6'h2B;
    repeat (3) @(posedge clk);
    #1 chk(irq_pin, 1'b1);
  endtask
  task automatic t_indirect();
    wr(8'h04, 8'h09);
    wr(8'h00, 8'h15);
    chk(wake, 6'h15);
    rd(8'h89, 8'h15);
    wr(8'h09, 8'hEA);
    chk(wake, 6'h2A);
    wr(8'h04, 8'h20);
    wr(8'h00, 8'hA5);
    rd(8'h20, 8'hA5);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
  endtask
  task automatic t_counter();
    wr(8'h0A, 8'h06);
    rd(8'h0A, 8'h06);
    op(sfr_pkg::pc_long_jump, 10'h3F0, 10'h3F0);
    op(sfr_pkg::pc_short_jump, 10'h0AB, 10'h2AB);
    op(sfr_pkg::pc_short_call, 10'h312, 10'h212);
    op(sfr_pkg::pc_long_call, 10'h155, 10'h155);
    op(sfr_pkg::pc_return, 10'h000, 10'h213);
    op(sfr_pkg::pc_return, 10'h000, 10'h2AC);
    op(sfr_pkg::pc_step, 10'h000, 10'h2AD);
    wr(8'h02, 8'h77);
    chk(pc, 10'h277);
  endtask
  task automatic t_flags();
    pulse(8'hD8, 8'h1D);
    pulse(8'hA0, 8'h1E);
    pulse(8'h04, 8'h16);
    pulse(8'h01, 8'h06);
    pulse(8'h02, 8'h1E);
    wr(8'h03, 8'hE0);
    rd(8'h03, 8'hE0);
  endtask
  task automatic t_timer();
    wr(8'h01, 8'h40);
    rd(8'h01, 8'h40);
    ticks(3'h1, 5);
    rd(8'h01, 8'h45);
    tmode = 2'h1;
    ticks(3'h2, 4);
    rd(8'h01, 8'h49);
    tmode = 2'h3;
    ticks(3'h4, 3);
    rd(8'h01, 8'h4C);
    tfall = 1'b1;
    lcfg = 1'b1;
    tmode = 2'h1;
    ticks(3'h4, 2);
    ticks(3'h2, 1);
    rd(8'h01, 8'h4E);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    #1 resetn = 1'b1;
    t_regs();
    t_indirect();
    t_counter();
    t_flags();
    t_timer();
    final_report();
  end
endmodule // mcu_core_special_registers_test
`default_nettype wire
